/* ctp_regs.svh */
// Control bit positions, reset values and tick rate of the cascadable timer block
`ifndef CTP_REGS_SVH
`define CTP_REGS_SVH

// Control register bit positions
`define CTP_CTL_EN_A_LOW 0
`define CTP_CTL_EN_A_HIGH 1
`define CTP_CTL_EN_B 2
`define CTP_CTL_CASCADE_A 3
`define CTP_CTL_PWM_A 4
`define CTP_CTL_AUTO_A_LOW 5
`define CTP_CTL_AUTO_A_HIGH 6
`define CTP_CTL_TIMER_OUTPUT_MODE_MODE 7

// Reset values
`define CTP_CTL_RESET 8'h00
`define CTP_CNT_RESET 8'h00
`define CTP_RLD_RESET 8'h00
`define CTP_PIN_RESET 1'b0

// Tick every eighth clock cycle
`define CTP_TICK_DIV 8

// Expiry threshold and cleared count
`define CTP_EXPIRE_AT 16'h0001
`define CTP_ZERO16 16'h0000
`define CTP_ZERO8 8'h00

`endif

/* ctp_pkg.sv */
// Types shared by the cascadable timer block
package ctp_pkg;

  typedef logic [7:0] ctp_byte_t;
  typedef logic [15:0] ctp_word_t;

  // Pulse generator phase of the first pair
  typedef enum logic [1:0] {
    CTP_PH_FIRST,
    CTP_PH_LOW,
    CTP_PH_HIGH
  } ctp_pwm_phase_e;

endpackage : ctp_pkg

/* ctp_tick_div.sv */
// Divider producing the one-cycle timer tick enable
`timescale 1ns/1ps
`include "ctp_regs.svh"

module ctp_tick_div #(
  parameter int DIV = `CTP_TICK_DIV
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  output logic tick_o
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] div_cnt;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      div_cnt <= '0;
    end else if (div_cnt == LAST) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (div_cnt == LAST);
    end
  end

endmodule : ctp_tick_div

/* ctp_pulse_out.sv */
// Flip-flop driving the timer output pin: set and cleared in pulse mode, toggled otherwise
`timescale 1ns/1ps
`include "ctp_regs.svh"

module ctp_pulse_out (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic pwm_i,
  input wire logic end_low_i,
  input wire logic end_high_i,
  output logic pin_o
);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pin_o <= `CTP_PIN_RESET;
    end else if (pwm_i) begin
      if (end_low_i) begin
        pin_o <= 1'b1;
      end else if (end_high_i) begin
        pin_o <= 1'b0;
      end
    end else if (end_low_i) begin
      // Every even timeout inverts, so steady reloads give equal halves
      pin_o <= ~pin_o;
    end
  end

endmodule : ctp_pulse_out

/* ctp_timers.sv */
// Four 8-bit down counters, cascadable into a 16-bit pulse timer and a 16-bit standard timer
`timescale 1ns/1ps
`include "ctp_regs.svh"

module ctp_timers #(
  parameter int TICK_DIV = `CTP_TICK_DIV
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ctl_wr_i,
  input wire ctp_pkg::ctp_byte_t ctl_wdata_i,
  input wire logic [3:0] cnt_wr_i,
  input wire ctp_pkg::ctp_byte_t cnt_wdata_i,
  input wire logic [3:0] low_reload_wr_i,
  input wire logic [1:0] high_reload_wr_i,
  input wire ctp_pkg::ctp_byte_t reload_wdata_i,
  output ctp_pkg::ctp_byte_t ctl_o,
  output ctp_pkg::ctp_byte_t timer_a_low_o,
  output ctp_pkg::ctp_byte_t timer_a_high_o,
  output ctp_pkg::ctp_byte_t timer_b_low_o,
  output ctp_pkg::ctp_byte_t timer_b_high_o,
  output ctp_pkg::ctp_byte_t pair_a_even_low_reload_o,
  output ctp_pkg::ctp_byte_t pair_a_odd_low_reload_o,
  output ctp_pkg::ctp_byte_t timer_b_low_reload_o,
  output ctp_pkg::ctp_byte_t timer_b_high_reload_o,
  output ctp_pkg::ctp_byte_t pair_a_even_high_reload_o,
  output ctp_pkg::ctp_byte_t pair_a_odd_high_reload_o,
  output logic even_timer_interrupt_o,
  output logic odd_timer_interrupt_o,
  output logic wide_timer_interrupt_o,
  output logic timer_output_pin_o
);

  import ctp_pkg::*;

  // One step of a down counter: {expired, next value}
  function automatic logic [16:0] ctp_step(
    input ctp_word_t cur,
    input ctp_word_t rld,
    input logic reload_en,
    input logic skip
  );
    logic [16:0] res;
    res = {1'b0, `CTP_ZERO16};
    if (cur <= `CTP_EXPIRE_AT) begin
      // Zero reached: reload unless disabled or overtaken by a write
      res = {1'b1, (reload_en && !skip) ? rld : `CTP_ZERO16};
    end else begin
      res = {1'b0, cur - `CTP_EXPIRE_AT};
    end
    return res;
  endfunction : ctp_step

  // Pulse generator needs the pair cascaded, in pulse mode and enabled
  function automatic logic ctp_pwm_on(input ctp_byte_t c);
    return c[`CTP_CTL_CASCADE_A] && c[`CTP_CTL_PWM_A] && c[`CTP_CTL_EN_A_LOW];
  endfunction : ctp_pwm_on

  // Split-mode bits sit at a fixed stride from the low timer's bit
  function automatic logic ctp_split_en(input ctp_byte_t c, input int idx);
    return c[`CTP_CTL_EN_A_LOW + idx];
  endfunction : ctp_split_en

  function automatic logic ctp_split_auto(input ctp_byte_t c, input int idx);
    return c[`CTP_CTL_AUTO_A_LOW + idx];
  endfunction : ctp_split_auto

  ctp_byte_t ctl;
  ctp_byte_t cnt [4];
  ctp_byte_t low_rld [4];
  ctp_byte_t high_rld [2];
  ctp_byte_t next_cnt [4];
  ctp_pwm_phase_e phase;
  ctp_pwm_phase_e next_phase;
  logic tick;
  logic [2:0] expired;
  logic [1:0] clr_en;
  logic [16:0] step_a;
  logic [16:0] step_b;
  logic [16:0] step8;
  ctp_word_t rld_sel;
  logic cur_high;
  logic skip_a;
  logic skip_b;
  logic pwm_active;

  // Internal clock only; no external count source exists
  ctp_tick_div #(
    .DIV(TICK_DIV)
  ) u_tick (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_o(tick)
  );

  assign pwm_active = ctp_pwm_on(ctl);
  assign skip_a = (|low_reload_wr_i[1:0]) || (|high_reload_wr_i);
  assign skip_b = |low_reload_wr_i[3:2];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_cnt[i] = cnt[i];
    end
    next_phase = phase;
    expired = '0;
    clr_en = '0;
    step_a = '0;
    step_b = '0;
    step8 = '0;
    rld_sel = {low_rld[1], low_rld[0]};
    cur_high = 1'b0;
    if (tick) begin
      if (ctl[`CTP_CTL_CASCADE_A]) begin
        if (ctl[`CTP_CTL_EN_A_LOW]) begin
          if (ctl[`CTP_CTL_PWM_A]) begin
            // First expiry decides by the pin only when it serves as timer output
            if (phase == CTP_PH_FIRST) begin
              cur_high = ctl[`CTP_CTL_TIMER_OUTPUT_MODE_MODE] ? timer_output_pin_o : 1'b1;
            end else begin
              cur_high = (phase == CTP_PH_HIGH);
            end
            rld_sel = cur_high ? {low_rld[1], low_rld[0]} : {high_rld[1], high_rld[0]};
          end
          step_a = ctp_step({cnt[1], cnt[0]}, rld_sel, 1'b1, skip_a);
          next_cnt[1] = step_a[15:8];
          next_cnt[0] = step_a[7:0];
          if (step_a[16]) begin
            if (ctl[`CTP_CTL_PWM_A]) begin
              if (cur_high) begin
                expired[1] = 1'b1;
                next_phase = CTP_PH_LOW;
              end else begin
                expired[0] = 1'b1;
                next_phase = CTP_PH_HIGH;
              end
            end else begin
              expired[0] = 1'b1;
            end
          end
        end
      end else begin
        for (int i = 0; i < 2; i++) begin
          if (ctp_split_en(ctl, i)) begin
            step8 = ctp_step({`CTP_ZERO8, cnt[i]}, {`CTP_ZERO8, low_rld[i]},
                             ctp_split_auto(ctl, i), low_reload_wr_i[i]);
            next_cnt[i] = step8[7:0];
            if (step8[16]) begin
              expired[i] = 1'b1;
              clr_en[i] = !ctp_split_auto(ctl, i);
            end
          end
        end
      end
      // Second pair has no split mode, so one enable governs both bytes
      if (ctl[`CTP_CTL_EN_B]) begin
        step_b = ctp_step({cnt[3], cnt[2]}, {low_rld[3], low_rld[2]}, 1'b1, skip_b);
        next_cnt[3] = step_b[15:8];
        next_cnt[2] = step_b[7:0];
        expired[2] = step_b[16];
      end
    end
  end

  // Count registers: software write has priority over write-back
  for (genvar g = 0; g < 4; g++) begin : g_cnt
    always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
        cnt[g] <= `CTP_CNT_RESET;
      end else if (cnt_wr_i[g]) begin
        cnt[g] <= cnt_wdata_i;
      end else begin
        cnt[g] <= next_cnt[g];
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
        low_rld[g] <= `CTP_RLD_RESET;
      end else if (low_reload_wr_i[g]) begin
        low_rld[g] <= reload_wdata_i;
      end
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_high_rld
    always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
        high_rld[g] <= `CTP_RLD_RESET;
      end else if (high_reload_wr_i[g]) begin
        high_rld[g] <= reload_wdata_i;
      end
    end
  end

  // Control: a write replaces all bits; counts are untouched, so no reload happens
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctl <= `CTP_CTL_RESET;
    end else begin
      if (ctl_wr_i) begin
        ctl <= ctl_wdata_i;
      end
      // Hardware single-shot clear overrides a same-cycle software write
      if (clr_en[0]) begin
        ctl[`CTP_CTL_EN_A_LOW] <= 1'b0;
      end
      if (clr_en[1]) begin
        ctl[`CTP_CTL_EN_A_HIGH] <= 1'b0;
      end
    end
  end

  // Phase restarts whenever the pulse generator is off or reconfigured
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      phase <= CTP_PH_FIRST;
    end else if (ctl_wr_i || !pwm_active) begin
      phase <= CTP_PH_FIRST;
    end else begin
      case (next_phase)
        CTP_PH_FIRST: phase <= CTP_PH_FIRST;
        CTP_PH_LOW: phase <= CTP_PH_LOW;
        CTP_PH_HIGH: phase <= CTP_PH_HIGH;
        default: phase <= CTP_PH_FIRST;
      endcase
    end
  end

  // Interrupt pulses; a second expiry before service is not tracked
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      even_timer_interrupt_o <= 1'b0;
    end else begin
      even_timer_interrupt_o <= expired[0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      odd_timer_interrupt_o <= 1'b0;
    end else begin
      odd_timer_interrupt_o <= expired[1];
    end
  end

  // Pair B interrupt belongs to its even byte; the odd byte has none
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wide_timer_interrupt_o <= 1'b0;
    end else begin
      wide_timer_interrupt_o <= expired[2];
    end
  end

  // Pin enabling at the port is left to software outside this block
  ctp_pulse_out u_pulse (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .pwm_i(pwm_active),
    .end_low_i(expired[0]),
    .end_high_i(expired[1]),
    .pin_o(timer_output_pin_o)
  );

  // Readback is pure wiring from the registers, free of side effects
  assign ctl_o = ctl;
  assign timer_a_low_o = cnt[0];
  assign timer_a_high_o = cnt[1];
  assign timer_b_low_o = cnt[2];
  assign timer_b_high_o = cnt[3];
  assign pair_a_even_low_reload_o = low_rld[0];
  assign pair_a_odd_low_reload_o = low_rld[1];
  assign timer_b_low_reload_o = low_rld[2];
  assign timer_b_high_reload_o = low_rld[3];
  assign pair_a_even_high_reload_o = high_rld[0];
  assign pair_a_odd_high_reload_o = high_rld[1];

endmodule : ctp_timers

/* ctp_irq_partner.sv */
// Interrupt controller and port pin model facing the timer block
`timescale 1ns/1ps
module ctp_irq_partner (
  input wire logic ref_clk_i,
  input wire logic odd_i,
  input wire logic pin_i,
  output int odd_cnt_o,
  output logic pin_o
);
  logic [7:0] port_b_direction_reg = 8'h02;
  logic timer_output_mode_sfr = 1'b1;
  // Pin not driven by the timer reads high
  assign pin_o = port_b_direction_reg[1] && timer_output_mode_sfr ? pin_i : 1'b1;
  initial odd_cnt_o = 0;
  always @(posedge ref_clk_i) begin
    odd_cnt_o <= odd_cnt_o + int'(odd_i);
  end
endmodule : ctp_irq_partner

/* ctp_timers_properties.sv */
// Port-level checks of the cascadable timer block
`timescale 1ns/1ps
module ctp_timers_properties
  import ctp_pkg::*;
#(
  parameter int TICK_DIV = 8
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ctl_wr_i,
  input wire logic [3:0] cnt_wr_i,
  input wire ctp_byte_t cnt_wdata_i,
  input wire ctp_byte_t ctl_o,
  input wire ctp_byte_t timer_a_low_o,
  input wire ctp_byte_t timer_a_high_o,
  input wire ctp_byte_t timer_b_low_o,
  input wire ctp_byte_t timer_b_high_o,
  input wire logic even_timer_interrupt_o,
  input wire logic odd_timer_interrupt_o,
  input wire logic wide_timer_interrupt_o,
  input wire logic timer_output_pin_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  ctp_byte_t prv;
  logic prv_wr;
  logic seen;
  int ph;
  wire logic hw_chg = timer_a_low_o != prv && !prv_wr;
  // Hardware moves the count only on the tick grid, so the phase must line up
  always_ff @(posedge ref_clk_i) begin
    prv <= timer_a_low_o;
    prv_wr <= cnt_wr_i[0];
    if (sys_rst_i || hw_chg) ph <= 0;
    else ph <= (ph == TICK_DIV - 1) ? 0 : ph + 1;
    if (sys_rst_i) seen <= 1'b0;
    else if (hw_chg) seen <= 1'b1;
  end
  property p_reset; $past(sys_rst_i) |-> ctl_o == 8'h00 && timer_b_low_o == 8'h00 && !wide_timer_interrupt_o; endproperty
  a_reset: assert property (p_reset) else $error("state not cleared by reset");
  property p_cnt_wr; cnt_wr_i[1] |=> timer_a_high_o == $past(cnt_wdata_i); endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost");
  property p_tick; hw_chg && seen |-> ph == TICK_DIV - 1; endproperty
  a_tick: assert property (p_tick) else $error("count moved off the tick grid");
  property p_low_zero; even_timer_interrupt_o && !ctl_o[3] |-> $past(timer_a_low_o) <= 8'h01 || $past(cnt_wr_i[0]); endproperty
  a_low_zero: assert property (p_low_zero) else $error("interrupt before count ran out");
  property p_wide_zero; wide_timer_interrupt_o |-> $past({timer_b_high_o, timer_b_low_o}) <= 16'h0001 || $past(|cnt_wr_i[3:2]); endproperty
  a_wide_zero: assert property (p_wide_zero) else $error("wide interrupt before full zero");
  property p_one_shot; $fell(ctl_o[1]) |-> timer_a_high_o == 8'h00 || $past(ctl_wr_i) || $past(cnt_wr_i[1]); endproperty
  a_one_shot: assert property (p_one_shot) else $error("enable cleared while counting");
  property p_pin_chg; $changed(timer_output_pin_o) |-> $past(even_timer_interrupt_o || odd_timer_interrupt_o) or ##[0:1] (even_timer_interrupt_o || odd_timer_interrupt_o); endproperty
  a_pin_chg: assert property (p_pin_chg) else $error("pin moved without a timeout");
  property p_pwm_pin; odd_timer_interrupt_o && ctl_o[4] |-> ##[0:1] !timer_output_pin_o; endproperty
  a_pwm_pin: assert property (p_pwm_pin) else $error("pin not low after high period");
  c_wide: cover property (wide_timer_interrupt_o);
  c_pair: cover property (even_timer_interrupt_o && ctl_o[3] && !ctl_o[4]);
  c_shot: cover property ($fell(ctl_o[1]));
  c_pwm: cover property (odd_timer_interrupt_o && ctl_o[4]);
endmodule : ctp_timers_properties

bind ctp_timers ctp_timers_properties #(.TICK_DIV(TICK_DIV)) i_props (.ref_clk_i, .sys_rst_i, .ctl_wr_i,
  .cnt_wr_i, .cnt_wdata_i, .ctl_o, .timer_a_low_o, .timer_a_high_o, .timer_b_low_o, .timer_b_high_o,
  .even_timer_interrupt_o, .odd_timer_interrupt_o, .wide_timer_interrupt_o, .timer_output_pin_o);

/* ctp_timers_test.sv */
// Self-checking bench for the cascadable timer block
`timescale 1ns/1ps
module ctp_timers_test;
  import ctp_pkg::*;
  localparam int DIV = 8;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [10:0] stb = 11'h000;
  ctp_byte_t wd = 8'h00;
  wire logic ctl_wr_i = stb[0];
  wire logic [3:0] cnt_wr_i = stb[4:1];
  wire logic [3:0] low_reload_wr_i = stb[8:5];
  wire logic [1:0] high_reload_wr_i = stb[10:9];
  wire ctp_byte_t ctl_wdata_i = wd;
  wire ctp_byte_t cnt_wdata_i = wd;
  wire ctp_byte_t reload_wdata_i = wd;
  ctp_byte_t ctl_o, timer_a_low_o, timer_a_high_o, timer_b_low_o, timer_b_high_o;
  logic even_timer_interrupt_o, odd_timer_interrupt_o, wide_timer_interrupt_o, timer_output_pin_o;
  logic pin, pin_at;
  int cyc = 0, odd_seen, miscompares = 0, total_checks = 0;
  ctp_timers #(.TICK_DIV(DIV)) i_dut (.ref_clk_i, .sys_rst_i, .ctl_wr_i, .ctl_wdata_i, .cnt_wr_i,
    .cnt_wdata_i, .low_reload_wr_i, .high_reload_wr_i, .reload_wdata_i, .ctl_o, .timer_a_low_o,
    .timer_a_high_o, .timer_b_low_o, .timer_b_high_o, .pair_a_even_low_reload_o(),
    .pair_a_odd_low_reload_o(), .timer_b_low_reload_o(), .timer_b_high_reload_o(),
    .pair_a_even_high_reload_o(), .pair_a_odd_high_reload_o(), .even_timer_interrupt_o,
    .odd_timer_interrupt_o, .wide_timer_interrupt_o, .timer_output_pin_o);
  ctp_irq_partner i_partner (.ref_clk_i, .odd_i(odd_timer_interrupt_o), .pin_i(timer_output_pin_o),
    .odd_cnt_o(odd_seen), .pin_o(pin));
  wire logic [2:0] ev = {wide_timer_interrupt_o, odd_timer_interrupt_o, even_timer_interrupt_o};
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) cyc <= cyc + 1;

  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_gap(input int got, input int exp);
    chk_val(16'(got), 16'(exp));
  endtask : chk_gap
  // Expiry of zero or one takes a single tick
  function automatic int gap(input int v);
    return DIV * (v < 1 ? 1 : v);
  endfunction : gap
  // Strobe offsets: 0 control, 1 count, 5 low reload, 9 high reload
  task automatic wr(input int sh, input logic [3:0] s, input ctp_byte_t d);
    @(posedge ref_clk_i);
    stb <= 11'(s) << sh;
    wd <= d;
    @(posedge ref_clk_i);
    stb <= 11'h000;
  endtask : wr
  // Pin is read two cycles on; its flop changes on the same edge as the interrupt
  task automatic wait_ev(input int w, output int t);
    t = -1;
    for (int i = 0; i < 5000 && t < 0; i++) begin
      @(posedge ref_clk_i);
      #1;
      if (ev[w] === 1'b1) t = cyc;
    end
    if (t < 0) chk_gap(0, 1);
    repeat (2) @(posedge ref_clk_i);
    #1;
    pin_at = pin;
  endtask : wait_ev

  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial begin
    int t0, t1, r, hi, n;
    logic h;
    t0 = $urandom(32);
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk_val(16'(ctl_o), 16'h0000);
    r = 2 + $urandom % 6;
    wr(5, 4'h1, 8'(r));
    wr(1, 4'h1, 8'h03);
    wr(0, 4'h1, 8'h21);
    wait_ev(0, t0);
    chk_val(16'(timer_a_low_o), 16'(r));
    for (int i = 0; i < 2; i++) begin
      h = pin_at;
      wait_ev(0, t1);
      chk_gap(t1 - t0, gap(r));
      chk_val(16'(pin_at), {15'h0000, ~h});
      t0 = t1;
    end
    // Reload changed mid-run takes effect at the next expiry
    r = 2 + $urandom % 6;
    wr(5, 4'h1, 8'(r));
    wr(1, 4'h2, 8'h09);
    wait_ev(0, t0);
    wait_ev(0, t1);
    chk_gap(t1 - t0, gap(r));
    wr(1, 4'h2, 8'h04);
    wr(0, 4'h1, 8'h02);
    wait_ev(1, t0);
    chk_val(16'({ctl_o[1], timer_a_high_o}), 16'h0000);
    // Wide timer runs beside the split timer
    r = 16'h0100 + $urandom % 16;
    wr(5, 4'h4, 8'(r));
    wr(5, 4'h8, 8'(r >> 8));
    wr(0, 4'h1, 8'h25);
    wait_ev(2, t0);
    chk_val({timer_b_high_o, timer_b_low_o}, 16'(r));
    wait_ev(2, t1);
    chk_gap(t1 - t0, gap(r));
    r = 1 + $urandom % 8;
    hi = 1 + $urandom % 8;
    wr(5, 4'h1, 8'(r));
    wr(5, 4'h2, 8'h00);
    wr(9, 4'h1, 8'(hi));
    wr(9, 4'h2, 8'h00);
    wr(0, 4'h1, 8'h19);
    wait_ev(1, t0);
    chk_val(16'(pin_at), 16'h0000);
    wait_ev(0, t1);
    chk_gap(t1 - t0, gap(r));
    chk_val(16'(pin_at), 16'h0001);
    chk_val({timer_a_high_o, timer_a_low_o}, 16'(hi));
    wait_ev(1, t0);
    chk_gap(t0 - t1, gap(hi));
    // Output mode with the pin low starts from the high reload
    n = odd_seen;
    wr(0, 4'h1, 8'h99);
    wait_ev(0, t1);
    chk_gap(odd_seen, n);
    // Cascaded standard mode: one even interrupt per full 16-bit count
    n = odd_seen;
    wr(5, 4'h2, 8'h01);
    wr(0, 4'h1, 8'h09);
    wait_ev(0, t0);
    chk_val({timer_a_high_o, timer_a_low_o}, 16'(256 + r));
    wait_ev(0, t1);
    chk_gap(t1 - t0, gap(256 + r));
    chk_gap(odd_seen, n);
    end_of_test();
  end
endmodule : ctp_timers_test
